// [core/one_pkg.sv]
// constants and carrier types shared by the output noise estimator
// assumes a 100 MHz system clock and samples paced by the demodulator

package one_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned CLK_HZ             = 1000000000 / CLK_PERIOD_NS;
	localparam int unsigned SAMPLE_RATE_HZ     = 512;
	localparam int unsigned SAMPLE_PERIOD_NOM  = CLK_HZ / SAMPLE_RATE_HZ;
	localparam int unsigned RATE_TOL_SHIFT     = 4;
	localparam int unsigned RATE_CNT_W         = 18;

	// ----------------------------------------
	// datapath widths
	// ----------------------------------------
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned ACC_W    = 40;
	localparam int unsigned DEV_W    = 17;
	localparam int unsigned COEF_W   = 16;
	localparam int unsigned FRAC_W   = 12;
	localparam int unsigned NOISE_W  = 24;
	localparam int unsigned CHAN_N   = 3;

	// ----------------------------------------
	// scaling
	// ----------------------------------------
	// sqrt(pi/2) in q4.12, mean abs deviation to rms for gaussian noise
	localparam logic [15:0] GAUSS_RMS_Q12 = 16'h140e;
	localparam logic [2:0]  TC_RESET      = 3'h0;

	// time constant codes 10ms,30ms,100ms,300ms,1s,3s,10s,30s
	// averaging length 2**shift samples, 40 to 68 time constants
	localparam logic [4:0] AVG_SHIFT [8] = '{5'h08, 5'h0a, 5'h0b, 5'h0d,
	                                         5'h0f, 5'h10, 5'h12, 5'h14};
	localparam logic [4:0] AVG_SHIFT_MIN = 5'h08;
	localparam logic [4:0] AVG_SHIFT_MAX = 5'h14;
	// 1/sqrt(enbw) = 2*sqrt(tc) for a single pole, q4.12
	localparam logic [15:0] ENBW_INV_SQRT_Q12 [8] = '{16'h0333, 16'h058b, 16'h0a1f, 16'h1187,
	                                                  16'h2000, 16'h376d, 16'h6531, 16'haf45};

	// ----------------------------------------
	// carriers and states
	// ----------------------------------------
	typedef struct packed {
		logic signed [15:0] inphase;
		logic signed [15:0] quadrature;
		logic signed [15:0] magnitude;
	} one_sample_s;

	typedef struct packed {
		logic [23:0] inphase_noise_estimate;
		logic [23:0] quadrature_noise_estimate;
		logic [23:0] magnitude_noise_estimate;
	} one_noise_s;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_MEAN  = 5'h02,
		ST_DEV   = 5'h04,
		ST_GAUSS = 5'h08,
		ST_BAND  = 5'h10
	} one_state_e;

endpackage

// [core/one_channel.sv]
// one quantity: moving mean, mean absolute deviation and scaled noise
// assumes the sample and coefficients stay still while a step runs

`timescale 1ns/1ns

module one_channel
	import one_pkg::*;
(
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic signed [15:0]  sample_i,
	input  wire logic [4:0]          shift_i,
	input  wire logic [15:0]         band_gain_i,
	input  wire logic                step_mean_i,
	input  wire logic                step_dev_i,
	input  wire logic                step_gauss_i,
	input  wire logic                step_band_i,
	output logic [23:0]              noise_o
);

	logic signed [39:0] mean_acc;
	logic [39:0]        mad_acc;
	logic signed [39:0] mean_full;
	logic signed [15:0] mean;
	logic signed [16:0] dev;
	logic [16:0]        abs_dev;
	logic [16:0]        mean_absolute_deviation;
	logic [32:0]        gauss_prod;
	logic [20:0]        gauss_term;
	logic [36:0]        band_prod;

	// ----------------------------------------
	// combinational terms
	// ----------------------------------------
	assign mean_full               = mean_acc >>> shift_i;
	assign mean                    = mean_full[15:0];
	assign dev                     = {sample_i[15], sample_i} - {mean[15], mean};
	assign abs_dev                 = dev[16] ? 17'(-dev) : 17'(dev);
	assign mean_absolute_deviation = 17'(mad_acc >> shift_i);
	assign gauss_prod              = 33'(mean_absolute_deviation) * 33'(GAUSS_RMS_Q12);
	assign band_prod               = 37'(gauss_term) * 37'(band_gain_i);

	// ----------------------------------------
	// accumulators
	// ----------------------------------------
	// no preset on range changes; only reset clears them
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mean_acc <= '0;
		end else if (step_mean_i) begin
			mean_acc <= mean_acc + 40'(sample_i) - mean_full;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mad_acc <= '0;
		end else if (step_dev_i) begin
			mad_acc <= mad_acc + 40'(abs_dev) - (mad_acc >> shift_i);
		end
	end

	// ----------------------------------------
	// scaling
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gauss_term <= '0;
		end else if (step_gauss_i) begin
			gauss_term <= gauss_prod[32:12];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			noise_o <= '0;
		end else if (step_band_i) begin
			noise_o <= band_prod[36] ? 24'hffffff : band_prod[35:12];
		end
	end

	chk_mean_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!step_mean_i |=> $stable(mean_acc))
		else $error("mean moved without a step");

	chk_mad_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!step_dev_i |=> $stable(mad_acc))
		else $error("deviation average moved without a step");

	chk_zero_dev: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		step_dev_i && dev == 17'h0 && mad_acc == 40'h0 |=> mad_acc == 40'h0)
		else $error("zero deviation raised the average");

endmodule

// [core/one_estimator.sv]
// top of the output noise estimator for in-phase, quadrature, magnitude
// assumes one sample strobe per 512 Hz period from the demodulator
//
// Contract
// - moving mean kept per quantity
// - deviation is sample minus current mean
// - average absolute deviation forms noise basis
// - fixed gaussian factor converts to rms
// - all quantities updated once per sample
// - one averaging length from time constant
// - divide by root of noise bandwidth
// - computation runs continuously, never gated
// - sensitivity change causes no preset

`timescale 1ns/1ns

module one_estimator
	import one_pkg::*;
#(
	parameter int unsigned SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NOM
)
(
	input  wire logic        REF_CLK_I,
	input  wire logic        RESET_N_I,
	input  wire one_sample_s SAMPLE_I,
	input  wire logic        SAMPLE_VALID_I,
	input  wire logic [2:0]  TIME_CONSTANT_I,
	output logic             SAMPLE_READY_O,
	output one_noise_s       NOISE_O,
	output logic             NOISE_VALID_O,
	output logic             RATE_FAULT_O
);

	localparam logic [17:0] PERIOD  = RATE_CNT_W'(SAMPLE_PERIOD_CYC);
	localparam logic [17:0] TOL     = RATE_CNT_W'(SAMPLE_PERIOD_CYC >> RATE_TOL_SHIFT);
	localparam logic [17:0] CNT_MAX = '1;

	logic               rst_meta;
	logic               rst_n;
	one_state_e         state;
	one_state_e         next_state;
	one_sample_s        held;
	logic [2:0]         tc_sel;
	logic [4:0]         shift;
	logic [15:0]        band_gain;
	logic               accept;
	logic signed [15:0] chan_sample [CHAN_N];
	logic [23:0]        chan_noise  [CHAN_N];
	logic [17:0]        gap_cnt;
	logic               seen_first;

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	assign SAMPLE_READY_O = (state == ST_IDLE);
	assign accept         = SAMPLE_VALID_I && SAMPLE_READY_O;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_MEAN;
				end
			end
			ST_MEAN: begin
				next_state = ST_DEV;
			end
			ST_DEV: begin
				next_state = ST_GAUSS;
			end
			ST_GAUSS: begin
				next_state = ST_BAND;
			end
			ST_BAND: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// sample and time constant capture
	// ----------------------------------------
	// the time constant is taken with each sample so a change never splits a step
	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			held   <= '0;
			tc_sel <= TC_RESET;
		end else if (accept) begin
			held   <= SAMPLE_I;
			tc_sel <= TIME_CONSTANT_I;
		end
	end

	assign shift     = AVG_SHIFT[tc_sel];
	assign band_gain = ENBW_INV_SQRT_Q12[tc_sel];

	assign chan_sample[0] = held.inphase;
	assign chan_sample[1] = held.quadrature;
	assign chan_sample[2] = held.magnitude;

	// ----------------------------------------
	// per quantity datapaths
	// ----------------------------------------
	// no select input exists: every estimate is always kept current
	for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
		one_channel u_chan (
			.clk_i        (REF_CLK_I),
			.rst_n_i      (rst_n),
			.sample_i     (chan_sample[c]),
			.shift_i      (shift),
			.band_gain_i  (band_gain),
			.step_mean_i  (state == ST_MEAN),
			.step_dev_i   (state == ST_DEV),
			.step_gauss_i (state == ST_GAUSS),
			.step_band_i  (state == ST_BAND),
			.noise_o      (chan_noise[c])
		);
	end

	assign NOISE_O.inphase_noise_estimate    = chan_noise[0];
	assign NOISE_O.quadrature_noise_estimate = chan_noise[1];
	assign NOISE_O.magnitude_noise_estimate  = chan_noise[2];

	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			NOISE_VALID_O <= 1'b0;
		end else begin
			NOISE_VALID_O <= (state == ST_BAND);
		end
	end

	// ----------------------------------------
	// sample rate monitor
	// ----------------------------------------
	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			gap_cnt <= '0;
		end else if (accept) begin
			gap_cnt <= 18'h00001;
		end else if (gap_cnt != CNT_MAX) begin
			gap_cnt <= gap_cnt + 18'h00001;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			seen_first   <= 1'b0;
			RATE_FAULT_O <= 1'b0;
		end else if (accept) begin
			seen_first   <= 1'b1;
			RATE_FAULT_O <= seen_first && ((gap_cnt + TOL < PERIOD) || (gap_cnt > PERIOD + TOL));
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_accept_start: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		accept |=> state == ST_MEAN)
		else $error("accepted sample did not start an update");

	chk_idle_stays: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		state == ST_IDLE && !SAMPLE_VALID_I |=> state == ST_IDLE)
		else $error("update started without a strobe");

	chk_step_order: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		state == ST_MEAN |=> state == ST_DEV ##1 state == ST_GAUSS ##1 state == ST_BAND ##1 state == ST_IDLE)
		else $error("update steps out of order");

	chk_valid_delay: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		accept |-> ##1 !NOISE_VALID_O [*4] ##1 NOISE_VALID_O ##1 !NOISE_VALID_O)
		else $error("noise valid not five cycles after sample");

	chk_tc_stable: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		state != ST_IDLE && !$past(accept) |-> $stable(shift) && $stable(band_gain))
		else $error("averaging length moved during an update");

	chk_shift_range: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		shift >= AVG_SHIFT_MIN && shift <= AVG_SHIFT_MAX)
		else $error("averaging length outside its range");

	chk_busy_refuse: assert property (@(posedge REF_CLK_I) disable iff (!rst_n)
		state != ST_IDLE |-> !SAMPLE_READY_O ##1 state != ST_MEAN)
		else $error("update restarted while busy");

	chk_reset_clear: assert property (@(posedge REF_CLK_I)
		$rose(rst_n) |-> NOISE_O == '0 && !NOISE_VALID_O)
		else $error("outputs not clear after reset");

endmodule

// [testbench/one_demod_model.sv]
// demodulator model: sample source behind a valid/ready handshake
// assumes its tasks are entered 1 ns after a rising clock edge
`timescale 1ns/1ns

module one_demod_model
	import one_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   ready_i,
	output one_sample_s sample_o,
	output logic        valid_o,
	output logic [2:0]  tc_o
);
	initial begin
		sample_o = '0;
		valid_o  = 1'b0;
		tc_o     = 3'h0;
	end

	// released lines show the inverse of the last value, never a stale copy
	task automatic release_bus();
		valid_o  = 1'b0;
		sample_o = ~sample_o;
		tc_o     = ~tc_o;
	endtask

	// request held until ready is seen high at a rising edge, for at most 16 edges
	task automatic send(input one_sample_s s, input logic [2:0] tc, output logic ok);
		int   n;
		logic rdy;
		sample_o = s;
		tc_o     = tc;
		valid_o  = 1'b1;
		n        = 0;
		do begin
			rdy = ready_i;
			@(posedge clk_i);
			n++;
		end while (!rdy && n < 16);
		#1;
		release_bus();
		ok = rdy;
	endtask

	// one-cycle strobe that ignores ready
	task automatic strobe(input one_sample_s s);
		sample_o = s;
		valid_o  = 1'b1;
		@(posedge clk_i);
		#1;
		release_bus();
	endtask
endmodule

// [testbench/tb.sv]
// self-checking bench for the output noise estimator
// assumes one_demod_model drives the sample side
`timescale 1ns/1ns

module tb
	import one_pkg::*;
;
	localparam int PER = 64;
	logic        clk;
	logic        rst_n;
	one_sample_s smp;
	logic        vld;
	logic [2:0]  tc;
	logic        rdy;
	one_noise_s  noise;
	logic        nvld;
	logic        fault;
	int          n_mismatch;
	int          check_count;
	longint      macc [3];
	longint      dacc [3];
	one_noise_s  exp_noise;

	initial clk = 1'b0;
	always #5 clk = ~clk;

	one_estimator #(.SAMPLE_PERIOD_CYC(PER)) one_estimator_i (
		.REF_CLK_I      (clk),
		.RESET_N_I      (rst_n),
		.SAMPLE_I       (smp),
		.SAMPLE_VALID_I (vld),
		.TIME_CONSTANT_I(tc),
		.SAMPLE_READY_O (rdy),
		.NOISE_O        (noise),
		.NOISE_VALID_O  (nvld),
		.RATE_FAULT_O   (fault)
	);

	one_demod_model one_demod_model_i (
		.clk_i   (clk),
		.ready_i (rdy),
		.sample_o(smp),
		.valid_o (vld),
		.tc_o    (tc)
	);

	task automatic check_bit(input string name, input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic check_noise(input one_noise_s e, input one_noise_s g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value noise expected %h seen %h", e, g);
		end
	endtask

	// reference arithmetic of the three channels
	task automatic ref_step(input one_sample_s s, input logic [2:0] c);
		logic signed [15:0] x [3];
		logic signed [15:0] mean;
		logic signed [16:0] dev;
		longint             m;
		longint             nz;
		x = '{s.inphase, s.quadrature, s.magnitude};
		for (int i = 0; i < 3; i++) begin
			macc[i] += x[i] - (macc[i] >>> AVG_SHIFT[c]);
			mean = 16'(macc[i] >>> AVG_SHIFT[c]);
			dev = 17'(x[i]) - 17'(mean);
			m = (dev < 0) ? -longint'(dev) : longint'(dev);
			dacc[i] += m - (dacc[i] >> AVG_SHIFT[c]);
			m = (dacc[i] >> AVG_SHIFT[c]) & 64'h1ffff;
			m = ((m * GAUSS_RMS_Q12) >> 12) & 64'h1fffff;
			nz = (m * ENBW_INV_SQRT_Q12[c]) >> 12;
			if (nz > 64'hffffff)
				nz = 64'hffffff;
			exp_noise[24 * (2 - i) +: 24] = 24'(nz);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		rst_n = 1'b0;
		macc = '{0, 0, 0};
		dacc = '{0, 0, 0};
		exp_noise = '0;
		repeat (4) @(posedge clk);
		#1;
		check_bit("reset ready", 1'b1, rdy);
		check_bit("reset valid", 1'b0, nvld);
		check_noise(exp_noise, noise);
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// one sample; gap is the spacing to the next, stray adds a refused strobe
	task automatic t_sample(input one_sample_s s, input logic [2:0] c, input int gap,
	                        input logic stray, input logic exp_fault);
		logic ok;
		one_demod_model_i.send(s, c, ok);
		check_bit("accepted", 1'b1, ok);
		ref_step(s, c);
		for (int i = 1; i < 5; i++) begin
			check_bit("busy ready", 1'b0, rdy);
			check_bit("early valid", 1'b0, nvld);
			if (stray && i == 2)
				one_demod_model_i.strobe(~s);
			else begin
				@(posedge clk);
				#1;
			end
		end
		check_bit("noise valid", 1'b1, nvld);
		check_bit("rate fault", exp_fault, fault);
		check_bit("ready again", 1'b1, rdy);
		check_noise(exp_noise, noise);
		repeat (gap - 5) begin
			@(posedge clk);
			#1;
		end
	endtask

	// time constant codes in turn, six samples each (all eight at 48 samples), accumulators carried across switches
	task automatic t_stream(input int n);
		one_sample_s s;
		for (int j = 0; j < n; j++) begin
			s.inphase = 16'((j % 2) ? 12000 + 37 * j : -9000 - 11 * j);
			s.quadrature = 16'((j % 3) ? 3000 + 100 * j : -2500);
			s.magnitude = 16'(20000 + (j % 3) * 4000);
			t_sample(s, 3'(j / 6), PER, j == 9, 1'b0);
		end
	endtask

	task automatic t_rate();
		one_sample_s a;
		one_sample_s b;
		a = '{16'h7fff, 16'h8000, 16'h0100};
		b = '{16'h8000, 16'h7fff, 16'h7fff};
		t_sample(a, 3'h7, 20, 1'b0, 1'b0);
		t_sample(b, 3'h7, PER + 4, 1'b0, 1'b1);
		t_sample(a, 3'h7, PER + 5, 1'b0, 1'b0);
		t_sample(b, 3'h7, PER, 1'b0, 1'b1);
		t_sample(a, 3'h7, PER, 1'b0, 1'b0);
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		n_mismatch = 0;
		check_count = 0;
		t_reset();
		t_stream(48);
		t_rate();
		t_reset();
		t_stream(7);
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		print_verdict();
	end
endmodule
